// ### design/setpoint_pkg.sv
// Shared constants for the setpoint control and latch block.
// Assumes register numbers are presented as plain 16-bit values by the macro or serial host.
package setpoint_pkg;

	// Register numbers.
	localparam logic [15:0] LATCH_FLAGS_REG = 16'h1004;
	localparam logic [15:0] CTRL_FIRST_REG = 16'h2035;
	localparam logic [15:0] CTRL_LAST_REG = 16'h2044;

	// Reset values.
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [15:0] LATCH_RESET = 16'h0000;

	// Field layout of a control register: three octal digits.
	localparam int ENERGIZE_LSB = 6;
	localparam int ENERGIZE_W = 2;
	localparam int SOURCE_LSB = 3;
	localparam int SOURCE_W = 3;
	localparam int FUNC_LSB = 0;
	localparam int FUNC_W = 3;

	// Bits inside the energize digit.
	localparam int ENERGIZE_INVERT_BIT = 0;
	localparam int ENERGIZE_INHIBIT_BIT = 1;

	// Activation source codes.
	localparam logic [2:0] SRC_REGISTER = 3'h0;
	localparam logic [2:0] SRC_SELECT = 3'h1;
	localparam logic [2:0] SRC_DI_A = 3'h2;
	localparam logic [2:0] SRC_DI_D = 3'h5;

	// Special function codes.
	localparam logic [2:0] FUNC_NONE = 3'h0;
	localparam logic [2:0] FUNC_LATCH_ON = 3'h1;
	localparam logic [2:0] FUNC_MANUAL_RESET = 3'h2;
	localparam logic [2:0] FUNC_LATCH_ON_MANUAL = 3'h3;
	localparam logic [2:0] FUNC_LATCH_OFF = 3'h4;
	localparam logic [2:0] FUNC_MENU_BAND = 3'h5;
	localparam logic [2:0] FUNC_MENU_TIMER = 3'h6;
	localparam logic [2:0] FUNC_MENU_TRIGGER = 3'h7;

	typedef enum logic {INH_ARMED, INH_RELEASED} inhibit_state_t;

endpackage : setpoint_pkg

// ### design/setpoint_eval.sv
// Combinational comparison and source selection for one setpoint.
// Assumes source and setpoint values are signed and stable for the cycle.
`timescale 1ns/1ps
module setpoint_eval
	import setpoint_pkg::*;
#(
	parameter int DATA_W = 32
) (
	input wire logic [7:0] ctrl,
	input wire logic [DATA_W-1:0] source_value,
	input wire logic [DATA_W-1:0] setpoint_value,
	input wire logic [3:0] digital_in,
	output logic source_ok,
	output logic raw_on
);
	logic [SOURCE_W-1:0] src;
	logic [ENERGIZE_W-1:0] energize;
	logic [1:0] pin_sel;
	logic above;

	assign src = ctrl[SOURCE_LSB +: SOURCE_W];
	assign energize = ctrl[ENERGIZE_LSB +: ENERGIZE_W];
	assign pin_sel = 2'(src - SRC_DI_A);

	always_comb begin
		above = 1'b0;
		source_ok = 1'b0;
		if (src == SRC_REGISTER) begin
			above = $signed(source_value) >= $signed(setpoint_value);
			source_ok = 1'b1;
		end else if (src >= SRC_DI_A && src <= SRC_DI_D) begin
			above = digital_in[pin_sel];
			source_ok = 1'b1;
		end
		// reserved inactive
		// Select mode and reserved codes leave the setpoint inactive.
	end

	assign raw_on = source_ok & (energize[ENERGIZE_INVERT_BIT] ? ~above : above);

endmodule : setpoint_eval

// ### design/startup_inhibit.sv
// Power-up inhibit tracker for one setpoint.
// Assumes raw_on already carries the chosen energize polarity.
`timescale 1ns/1ps
module startup_inhibit
	import setpoint_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic raw_on,
	output logic allow
);
	inhibit_state_t state_q;
	inhibit_state_t state_d;

	// rising inhibit
	// The relay side must be left once; for either polarity that means raw_on low.
	always_comb begin
		state_d = state_q;
		case (state_q)
			INH_ARMED: begin
				if (!raw_on) begin
					state_d = INH_RELEASED;
				end
			end
			INH_RELEASED: begin
				state_d = INH_RELEASED;
			end
			default: begin
				state_d = INH_ARMED;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= INH_ARMED;
		end else begin
			state_q <= state_d;
		end
	end

	assign allow = (state_q == INH_RELEASED);

endmodule : startup_inhibit

// ### design/setpoint_control_latch.sv
// Control registers, latch flags and relay drive for the advanced setpoints.
// Assumes a host that presents one register request per cycle and synchronous inputs.
`timescale 1ns/1ps
module setpoint_control_latch
	import setpoint_pkg::*;
#(
	parameter int NUM_SP = 16,
	parameter int DATA_W = 32
) (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [15:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	output logic [15:0] REG_RDATA,
	output logic REG_ACK,
	input wire logic [NUM_SP*DATA_W-1:0] SOURCE_VALUE,
	input wire logic [NUM_SP*DATA_W-1:0] SETPOINT_VALUE,
	input wire logic DIGITAL_INPUT_A,
	input wire logic DIGITAL_INPUT_B,
	input wire logic DIGITAL_INPUT_C,
	input wire logic DIGITAL_INPUT_D,
	input wire logic [NUM_SP-1:0] PANEL_UNLATCH,
	input wire logic LOCK_HOLD_UNLATCH,
	output logic [NUM_SP-1:0] RELAY,
	output logic [NUM_SP-1:0] MENU_ENTRY
);
	localparam int IDX_W = (NUM_SP > 1) ? $clog2(NUM_SP) : 1;

	logic [7:0] ctrl_q [NUM_SP];
	logic [NUM_SP-1:0] latch_q;
	logic [NUM_SP-1:0] latch_d;
	logic [NUM_SP-1:0] relay_d;
	logic [NUM_SP-1:0] menu_d;
	logic [NUM_SP-1:0] drive_prev_q;
	logic [NUM_SP-1:0] source_ok;
	logic [NUM_SP-1:0] raw_on;
	logic [NUM_SP-1:0] allow;
	logic [NUM_SP-1:0] drive;
	logic [NUM_SP-1:0] set_ev;
	logic [NUM_SP-1:0] clr_ev;
	logic [NUM_SP-1:0] latch_on_sel;
	logic [NUM_SP-1:0] latch_off_sel;
	logic [3:0] digital_in;
	logic [15:0] ctrl_off;
	logic ctrl_hit;
	logic latch_hit;
	logic [IDX_W-1:0] ctrl_idx;
	logic [15:0] rdata_d;

	assign digital_in = {DIGITAL_INPUT_D, DIGITAL_INPUT_C, DIGITAL_INPUT_B, DIGITAL_INPUT_A};

	assign ctrl_off = REG_ADDR - CTRL_FIRST_REG;
	assign ctrl_hit = (REG_ADDR >= CTRL_FIRST_REG) && (REG_ADDR <= CTRL_LAST_REG)
		&& (ctrl_off < 16'(NUM_SP));
	assign ctrl_idx = ctrl_off[IDX_W-1:0];
	assign latch_hit = (REG_ADDR == LATCH_FLAGS_REG);

	// octal storage
	// The three octal digits are kept as raw bits, so reads return the low byte that was written.
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			for (int i = 0; i < NUM_SP; i++) begin
				ctrl_q[i] <= CTRL_RESET;
			end
		end else if (REG_WR && ctrl_hit) begin
			ctrl_q[ctrl_idx] <= REG_WDATA[7:0];
		end
	end

	for (genvar g = 0; g < NUM_SP; g++) begin : g_sp
		setpoint_eval #(
			.DATA_W(DATA_W)
		) u_eval (
			.ctrl(ctrl_q[g]),
			.source_value(SOURCE_VALUE[g*DATA_W +: DATA_W]),
			.setpoint_value(SETPOINT_VALUE[g*DATA_W +: DATA_W]),
			.digital_in(digital_in),
			.source_ok(source_ok[g]),
			.raw_on(raw_on[g])
		);

		startup_inhibit u_inhibit (
			.clk(CLOCK),
			.rst(RST),
			.raw_on(raw_on[g]),
			.allow(allow[g])
		);
	end

	always_comb begin
		for (int i = 0; i < NUM_SP; i++) begin
			drive[i] = raw_on[i]
				& (~ctrl_q[i][ENERGIZE_LSB + ENERGIZE_INHIBIT_BIT] | allow[i]);
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_SP; i++) begin
			latch_on_sel[i] = (ctrl_q[i][FUNC_LSB +: FUNC_W] == FUNC_LATCH_ON)
				|| (ctrl_q[i][FUNC_LSB +: FUNC_W] == FUNC_MANUAL_RESET)
				|| (ctrl_q[i][FUNC_LSB +: FUNC_W] == FUNC_LATCH_ON_MANUAL);
			latch_off_sel[i] = (ctrl_q[i][FUNC_LSB +: FUNC_W] == FUNC_LATCH_OFF);
			menu_d[i] = (ctrl_q[i][FUNC_LSB +: FUNC_W] >= FUNC_MENU_BAND);
		end
	end

	// Remembers the unlatched drive so a latch-off catches the on-to-off edge only;
	// a level test would relatch forever on an idle input right after release.
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			drive_prev_q <= '0;
		end else begin
			drive_prev_q <= drive;
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_SP; i++) begin
			set_ev[i] = (latch_on_sel[i] & drive[i])
				| (latch_off_sel[i] & drive_prev_q[i] & ~drive[i]);
			clr_ev[i] = (REG_WR & latch_hit & ~REG_WDATA[i]) | PANEL_UNLATCH[i]
				| LOCK_HOLD_UNLATCH;
			// A hardware latch event wins over any clear arriving in the same cycle.
			latch_d[i] = set_ev[i] | (REG_WR & latch_hit & REG_WDATA[i])
				| (latch_q[i] & ~clr_ev[i]);
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			latch_q <= LATCH_RESET[NUM_SP-1:0];
		end else begin
			latch_q <= latch_d;
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_SP; i++) begin
			if (latch_q[i] && latch_on_sel[i]) begin
				relay_d[i] = 1'b1;
			end else if (latch_q[i] && latch_off_sel[i]) begin
				relay_d[i] = 1'b0;
			end else begin
				relay_d[i] = drive[i];
			end
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			RELAY <= '0;
			MENU_ENTRY <= '0;
		end else begin
			RELAY <= relay_d;
			MENU_ENTRY <= menu_d;
		end
	end

	always_comb begin
		rdata_d = 16'h0000;
		if (latch_hit) begin
			rdata_d = 16'(latch_q);
		end else if (ctrl_hit) begin
			rdata_d = {8'h00, ctrl_q[ctrl_idx]};
		end
	end

	// Unmapped numbers still answer, reading zero, so the host never waits.
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			REG_RDATA <= 16'h0000;
			REG_ACK <= 1'b0;
		end else begin
			REG_ACK <= REG_WR | REG_RD;
			if (REG_RD) begin
				REG_RDATA <= rdata_d;
			end
		end
	end

	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (RST);

	sequence s_plain_above;
		ctrl_q[0] == 8'h00 && raw_on[0] && !latch_q[0];
	endsequence

	// Setpoint 3 carries the latch functions in the bench, so this event is really reached.
	sequence s_latch_on_event;
		latch_on_sel[3] && drive[3];
	endsequence

	sequence s_flag_dropped;
		!latch_q[0] && !set_ev[0];
	endsequence

	a_ack_after_request: assert property (
		(REG_WR || REG_RD) |=> REG_ACK ##1 (REG_ACK == $past(REG_WR || REG_RD)))
		else $error("register request not acknowledged");

	a_ctrl_write_store: assert property (
		(REG_WR && REG_ADDR == CTRL_LAST_REG) |=> ctrl_q[NUM_SP-1] == $past(REG_WDATA[7:0]))
		else $error("last control register did not take write");

	a_ctrl_readback: assert property (
		(REG_RD && REG_ADDR == CTRL_FIRST_REG && !REG_WR) |=> REG_RDATA == {8'h00, ctrl_q[0]})
		else $error("control register read mismatch");

	a_energize_above: assert property (
		s_plain_above |=> RELAY[0])
		else $error("relay not energized at or above setpoint");

	a_latch_set_wins: assert property (
		s_latch_on_event |=> latch_q[3] ##1 RELAY[3])
		else $error("latch-on event lost or relay not held");

	a_clear_releases: assert property (
		(REG_WR && latch_hit && !REG_WDATA[0] && !set_ev[0]) |=> s_flag_dropped or !latch_q[0])
		else $error("software clear did not release latch");

	a_pin_unlatch: assert property (
		(LOCK_HOLD_UNLATCH && !set_ev[0]) |=> !latch_q[0])
		else $error("lock or hold unlatch did not clear flag");

	a_reserved_off: assert property (
		(ctrl_q[0][SOURCE_LSB +: SOURCE_W] > SRC_DI_D && !latch_q[0]) |=> !RELAY[0])
		else $error("reserved source drove relay");

	a_inhibit_blocks: assert property (
		(ctrl_q[0][ENERGIZE_LSB + ENERGIZE_INHIBIT_BIT] && !allow[0] && !latch_q[0])
		|=> !RELAY[0])
		else $error("relay energized under startup inhibit");

	a_menu_no_latch: assert property (
		(menu_d[0] && !latch_q[0] && !(REG_WR && latch_hit)) |=> !latch_q[0] ##0 MENU_ENTRY[0])
		else $error("menu code latched or not flagged");

	a_ack_idle_low: assert property (
		!(REG_WR || REG_RD) |=> !REG_ACK)
		else $error("acknowledge without a request");

	a_rdata_holds: assert property (
		!REG_RD |=> $stable(REG_RDATA))
		else $error("read data changed without a read");

	a_unmapped_zero: assert property (
		(REG_RD && !latch_hit && !ctrl_hit) |=> REG_RDATA == 16'h0000)
		else $error("unmapped register read not zero");

	a_ctrl_first_store: assert property (
		(REG_WR && REG_ADDR == CTRL_FIRST_REG) |=> ctrl_q[0] == $past(REG_WDATA[7:0]))
		else $error("first control register did not take write");

	a_flags_readback: assert property (
		(REG_RD && latch_hit) |=> REG_RDATA[NUM_SP-1:0] == $past(latch_q))
		else $error("latch flags read mismatch");

	a_flag_write_sets: assert property (
		(REG_WR && latch_hit && REG_WDATA[0]) |=> latch_q[0])
		else $error("software flag write did not set flag");

	a_plain_follows: assert property (
		(!ctrl_q[0][ENERGIZE_LSB + ENERGIZE_INHIBIT_BIT] && !latch_q[0])
		|=> RELAY[0] == $past(raw_on[0]))
		else $error("relay does not follow comparison");

	a_pin_source: assert property (
		(ctrl_q[0][SOURCE_LSB +: SOURCE_W] == SRC_DI_A && !latch_q[0]
		&& !ctrl_q[0][ENERGIZE_LSB + ENERGIZE_INHIBIT_BIT])
		|=> RELAY[0] == $past(DIGITAL_INPUT_A ^ ctrl_q[0][ENERGIZE_LSB + ENERGIZE_INVERT_BIT]))
		else $error("pin source did not drive relay");

	a_select_off: assert property (
		(ctrl_q[0][SOURCE_LSB +: SOURCE_W] == SRC_SELECT && !latch_q[0]) |=> !RELAY[0])
		else $error("source selection mode drove relay");

	a_menu_flag_low: assert property (
		!menu_d[0] |=> !MENU_ENTRY[0])
		else $error("menu flagged without menu code");

	a_none_no_latch: assert property (
		(ctrl_q[0][FUNC_LSB +: FUNC_W] == FUNC_NONE && !latch_q[0] && !(REG_WR && latch_hit))
		|=> !latch_q[0])
		else $error("flag set with no latching selected");

	a_inhibit_release: assert property (
		!raw_on[0] |=> allow[0])
		else $error("inhibit not released after leaving the energize side");

	a_inhibit_keeps: assert property (
		allow[0] |=> allow[0])
		else $error("inhibit re-armed without reset");

	a_latch_on_hold: assert property (
		(latch_q[3] && latch_on_sel[3]) |=> RELAY[3])
		else $error("latched-on relay dropped");

	a_latch_off_hold: assert property (
		(latch_q[3] && latch_off_sel[3]) |=> !RELAY[3])
		else $error("latched-off relay energized");

	a_latch_off_event: assert property (
		(latch_off_sel[3] && drive_prev_q[3] && !drive[3]) |=> latch_q[3])
		else $error("latch-off event lost");

	a_panel_unlatch: assert property (
		(PANEL_UNLATCH[3] && !set_ev[3] && !(REG_WR && latch_hit && REG_WDATA[3]))
		|=> !latch_q[3])
		else $error("panel unlatch did not clear flag");

endmodule : setpoint_control_latch

// ### testbench/relay_field.sv
// Field-side model of the four digital input pins.
// Assumes the bench asks for pin levels through di_req.
`timescale 1ns/1ps
module relay_field (
	input wire logic clock,
	input wire logic [3:0] di_req,
	output logic di_a,
	output logic di_b,
	output logic di_c,
	output logic di_d
);
	initial {di_d, di_c, di_b, di_a} = 4'h0;
	// Contacts move just after the edge, so the block never sees them change on it.
	always @(posedge clock) begin
		#1;
		{di_d, di_c, di_b, di_a} = di_req;
	end
endmodule : relay_field

// ### testbench/setpoint_control_latch_bench.sv
// Self-checking bench for the setpoint control and latch block.
// Assumes relay_field drives the pins and a 125 MHz clock.
`timescale 1ns/1ps
module setpoint_control_latch_bench;
	import setpoint_pkg::*;
	logic CLOCK, RST, REG_WR, REG_RD, REG_ACK, LOCK_HOLD_UNLATCH, pin_a, pin_b, pin_c, pin_d;
	logic [15:0] REG_ADDR, REG_WDATA, REG_RDATA, PANEL_UNLATCH, RELAY, MENU_ENTRY, rd, lfsr;
	logic [511:0] SOURCE_VALUE, SETPOINT_VALUE;
	logic [7:0] shadow [16];
	logic [3:0] di_req;
	int num_errors, num_checks, k;
	setpoint_control_latch i_setpoint_control_latch (.CLOCK(CLOCK), .RST(RST), .REG_WR(REG_WR),
		.REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
		.REG_ACK(REG_ACK), .SOURCE_VALUE(SOURCE_VALUE), .SETPOINT_VALUE(SETPOINT_VALUE),
		.DIGITAL_INPUT_A(pin_a), .DIGITAL_INPUT_B(pin_b), .DIGITAL_INPUT_C(pin_c),
		.DIGITAL_INPUT_D(pin_d), .PANEL_UNLATCH(PANEL_UNLATCH),
		.LOCK_HOLD_UNLATCH(LOCK_HOLD_UNLATCH), .RELAY(RELAY), .MENU_ENTRY(MENU_ENTRY));
	relay_field i_relay_field (.clock(CLOCK), .di_req(di_req), .di_a(pin_a), .di_b(pin_b),
		.di_c(pin_c), .di_d(pin_d));
	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr_next
	// Pins count as at or above; selection and reserved sources never energize.
	function automatic logic exp_on(input logic e, input logic [2:0] s, input logic [3:0] di,
		input logic above);
		if (s == 3'h1 || s > 3'h5) return 1'b0;
		return ((s == 3'h0) ? above : di[s - 3'h2]) ^ e;
	endfunction : exp_on
	task automatic end_sim;
		if (num_errors == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_sim
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(posedge CLOCK);
		#1;
	endtask : cyc
	task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] data);
		cyc(1);
		REG_WR = wr;
		REG_RD = !wr;
		REG_ADDR = addr;
		REG_WDATA = data;
		cyc(1);
		REG_WR = 1'b0;
		REG_RD = 1'b0;
		check({15'h0, REG_ACK}, 16'h1);
		rd = REG_RDATA;
	endtask : access
	task automatic rd_check(input logic [15:0] addr, input logic [15:0] exp);
		access(1'b0, addr, 16'h0);
		check(rd, exp);
	endtask : rd_check
	task automatic do_reset(input int n);
		RST = 1'b1;
		SOURCE_VALUE = '0;
		cyc(n);
		check(RELAY, 16'h0);
		RST = 1'b0;
		cyc(3);
		check(RELAY, 16'hffff);
	endtask : do_reset
	initial begin
		CLOCK = 1'b0;
		forever #4 CLOCK = ~CLOCK;
	end
	initial begin
		repeat (20000) @(posedge CLOCK);
		num_errors++;
		end_sim();
	end
	initial begin
		{REG_WR, REG_RD, LOCK_HOLD_UNLATCH, REG_ADDR, REG_WDATA, PANEL_UNLATCH, di_req} = '0;
		SETPOINT_VALUE = '0;
		num_errors = 0;
		num_checks = 0;
		lfsr = 16'hff5d;
		do_reset(16);
		access(1'b1, CTRL_FIRST_REG, 16'h0080);
		cyc(3);
		check(RELAY, 16'hfffe);
		SOURCE_VALUE[31:0] = 32'hfffffffb;
		cyc(3);
		check(RELAY, 16'hfffe);
		SOURCE_VALUE[31:0] = 32'h0;
		cyc(3);
		check(RELAY, 16'hffff);
		rd_check(CTRL_LAST_REG, {8'h00, CTRL_RESET});
		rd_check(LATCH_FLAGS_REG, LATCH_RESET);
		for (int i = 0; i < 16; i++) begin
			lfsr = lfsr_next(lfsr);
			shadow[i] = lfsr[7:0] & 8'hf8;
			access(1'b1, 16'(CTRL_FIRST_REG + i), {lfsr[15:8], shadow[i]});
		end
		for (int i = 0; i < 16; i++) begin
			rd_check(16'(CTRL_FIRST_REG + i), {8'h00, shadow[i]});
		end
		lfsr = lfsr_next(lfsr);
		access(1'b1, LATCH_FLAGS_REG, lfsr);
		rd_check(LATCH_FLAGS_REG, lfsr);
		rd_check(16'h2034, 16'h0);
		rd_check(16'h2045, 16'h0);
		do_reset(2);
		for (int n = 0; n < 32; n++) begin
			lfsr = lfsr_next(lfsr);
			k = int'(lfsr[3:0]);
			di_req = lfsr[7:4];
			SOURCE_VALUE[k*32 +: 32] = lfsr[8] ? 32'h0 : 32'hfffffffb;
			access(1'b1, 16'(CTRL_FIRST_REG + k), {9'h0, n[0], n[3:1],
				n[0] ? 3'(5 + n[3:1] % 3) : 3'h0});
			cyc(3);
			check(RELAY, (16'hffff & ~(16'h1 << k)) |
				(16'(exp_on(n[0], n[3:1], lfsr[7:4], lfsr[8])) << k));
			check(MENU_ENTRY, n[0] ? 16'h1 << k : 16'h0);
			SOURCE_VALUE[k*32 +: 32] = 32'h0;
			access(1'b1, 16'(CTRL_FIRST_REG + k), 16'h0);
		end
		for (int f = 1; f < 5; f++) begin
			access(1'b1, 16'(CTRL_FIRST_REG + 3), 16'(f));
			SOURCE_VALUE[127:96] = 32'h0;
			cyc(3);
			SOURCE_VALUE[127:96] = 32'hfffffffb;
			cyc(3);
			check({15'h0, RELAY[3]}, 16'(f < 4));
			if (f == 4) begin
				SOURCE_VALUE[127:96] = 32'h0;
				cyc(3);
				check({15'h0, RELAY[3]}, 16'h0);
			end
			rd_check(LATCH_FLAGS_REG, 16'h0008);
			if (f == 2) begin
				PANEL_UNLATCH[3] = 1'b1;
			end else if (f == 3) begin
				LOCK_HOLD_UNLATCH = 1'b1;
			end else begin
				access(1'b1, LATCH_FLAGS_REG, 16'h0);
			end
			cyc(1);
			PANEL_UNLATCH = 16'h0;
			LOCK_HOLD_UNLATCH = 1'b0;
			cyc(3);
			check({15'h0, RELAY[3]}, 16'(f == 4));
			rd_check(LATCH_FLAGS_REG, 16'h0);
		end
		end_sim();
	end
endmodule : setpoint_control_latch_bench
